// file: pil_panel_interlock.sv
// Panel switch, lamp, reader power and interlock failure logic.
// Assumes panel switches are raw pins; controller signals share clk.
`timescale 1ns/1ps
`include "pil_defines.svh"

module pil_panel_interlock (
  input wire logic clk,
  input wire logic rst,
  input wire logic halt_btn,
  input wire logic setup_btn,
  input wire logic log_btn,
  input wire logic power_btn,
  input wire logic mains_permit_sw,
  input wire logic host_supply_sw,
  input wire logic maint_mode_sw,
  input wire logic fault_reset_btn,
  input wire logic phase_freeze_selector,
  input wire logic [`PIL_NUM_RDR_GUARD-1:0] scanner_guard_override,
  input wire logic [`PIL_NUM_HOST_GUARD-1:0] host_guard_override,
  input wire logic [`PIL_NUM_RDR_GUARD-1:0] scanner_fault,
  input wire logic [`PIL_NUM_HOST_GUARD-1:0] host_fault,
  input wire logic operational_fault,
  input wire logic dc_supplies_ok,
  input wire logic ready_lost,
  input wire logic param_ready_only,
  input wire logic [`PIL_SYNC_SEL_W-1:0] sync_sel_1,
  input wire logic [`PIL_SYNC_SEL_W-1:0] sync_sel_2,
  input wire logic [`PIL_NUM_SYNC_SRC-1:0] sync_sources,
  input wire logic [`PIL_NUM_PHASE-1:0] phase_freeze_req,
  output pil_pkg::pil_ctl_t ctl,
  output pil_pkg::pil_lamps_t lamps,
  output logic reader_ac_power,
  output logic system_power,
  output logic interlock_supply,
  output logic [`PIL_NUM_RDR_GUARD-1:0] override_lamp,
  output logic [`PIL_NUM_HOST_GUARD-1:0] host_override_lamp,
  output logic interlock_fail_lamp,
  output logic operational_fail_lamp,
  output logic [1:0] selectable_sync_probe,
  output logic [`PIL_NUM_PHASE-1:0] phase_freeze
);

  localparam int DBW = $clog2(`PIL_DEBOUNCE_CYC + 1);
  localparam int NRS = `PIL_NUM_RDR_GUARD;
  localparam int NHS = `PIL_NUM_HOST_GUARD;
  localparam int NSW = `PIL_NUM_BTN + NRS + NHS;

  // ----------------------------------------
  // Synchronise and debounce panel inputs
  // ----------------------------------------
  logic [NSW-1:0] raw;
  logic [NSW-1:0] s1;
  logic [NSW-1:0] s2;
  logic [NSW-1:0] deb;
  logic [NSW-1:0] next_deb;
  logic [NSW-1:0][DBW-1:0] cnt;
  logic [NSW-1:0][DBW-1:0] next_cnt;

  assign raw = {host_guard_override, scanner_guard_override, phase_freeze_selector,
                fault_reset_btn, maint_mode_sw, host_supply_sw, mains_permit_sw,
                power_btn, log_btn, setup_btn, halt_btn};

  genvar gi;
  generate
    for (gi = 0; gi < NSW; gi++) begin : g_deb
      always_comb begin
        next_deb[gi] = deb[gi];
        next_cnt[gi] = '0;
        if (s2[gi] != deb[gi]) begin
          if (cnt[gi] == DBW'(`PIL_DEBOUNCE_CYC - 1)) begin
            next_deb[gi] = s2[gi];
          end else begin
            next_cnt[gi] = cnt[gi] + DBW'(1);
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      deb <= '0;
      cnt <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      deb <= next_deb;
      cnt <= next_cnt;
    end
  end

  logic halt_d, setup_d, log_d, pwr_d, mains_d, hsup_d, maint_d, freset_d, freeze_d;
  logic [NRS-1:0] rg_d;
  logic [NHS-1:0] hg_d;
  assign halt_d = deb[`PIL_BTN_HALT];
  assign setup_d = deb[`PIL_BTN_SETUP];
  assign log_d = deb[`PIL_BTN_LOG];
  assign pwr_d = deb[`PIL_BTN_PWR];
  assign mains_d = deb[`PIL_BTN_MAINS];
  assign hsup_d = deb[`PIL_BTN_HOSTSUP];
  assign maint_d = deb[`PIL_BTN_MAINT];
  assign freset_d = deb[`PIL_BTN_FRESET];
  assign freeze_d = deb[`PIL_BTN_FREEZE];
  assign rg_d = deb[`PIL_NUM_BTN +: NRS];
  assign hg_d = deb[`PIL_NUM_BTN + NRS +: NHS];

  // ----------------------------------------
  // Power and failure control
  // ----------------------------------------
  pil_pkg::pil_pwr_state_t st;
  pil_pkg::pil_pwr_state_t next_st;
  logic log_en, next_log_en;
  logic log_prev, pwr_prev, next_log_prev, next_pwr_prev;
  logic il_fail, op_fail, next_il_fail, next_op_fail;
  logic [NRS-1:0] rg_eff;
  logic [NHS-1:0] hg_eff;
  logic il_fault, fault_clear;

  assign rg_eff = maint_d ? rg_d : '0;
  assign hg_eff = maint_d ? hg_d : '0;
  assign il_fault = |(scanner_fault & ~rg_eff) | |(host_fault & ~hg_eff);
  assign fault_clear = maint_d & freset_d;

  // Log-strip option toggles on each debounced press
  always_comb begin
    next_log_prev = log_d;
    next_log_en = log_en;
    if (log_d && !log_prev) begin
      next_log_en = !log_en;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      log_en <= 1'b0;
      log_prev <= 1'b0;
    end else begin
      log_en <= next_log_en;
      log_prev <= next_log_prev;
    end
  end

  // Failure latches: a new failure wins over a fault reset in the same cycle
  always_comb begin
    next_il_fail = il_fail;
    next_op_fail = op_fail;
    if (fault_clear) begin
      next_il_fail = 1'b0;
      next_op_fail = 1'b0;
    end
    if (il_fault && mains_d) begin
      next_il_fail = 1'b1;
    end
    if (operational_fault && mains_d) begin
      next_op_fail = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      il_fail <= 1'b0;
      op_fail <= 1'b0;
    end else begin
      il_fail <= next_il_fail;
      op_fail <= next_op_fail;
    end
  end

  // Reader power: any unmasked scanner or host fault trips, even with the reader off, so a
  // latched interlock failure can never coexist with ac power; the trip holds until a
  // maintenance fault reset arrives with the fault gone
  always_comb begin
    next_st = st;
    next_pwr_prev = pwr_d;
    case (st)
      pil_pkg::PIL_PWR_OFF: begin
        if (il_fault) begin
          next_st = pil_pkg::PIL_PWR_TRIP;
        end else if (pwr_d && !pwr_prev && mains_d && hsup_d) begin
          next_st = pil_pkg::PIL_PWR_ON;
        end
      end
      pil_pkg::PIL_PWR_ON: begin
        if (il_fault) begin
          next_st = pil_pkg::PIL_PWR_TRIP;
        end else if (!mains_d || !hsup_d || (pwr_d && !pwr_prev)) begin
          next_st = pil_pkg::PIL_PWR_OFF;
        end
      end
      pil_pkg::PIL_PWR_TRIP: begin
        if (fault_clear && !il_fault) begin
          next_st = pil_pkg::PIL_PWR_OFF;
        end
      end
      default: next_st = pil_pkg::PIL_PWR_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= pil_pkg::PIL_PWR_OFF;
      pwr_prev <= 1'b0;
    end else begin
      st <= next_st;
      pwr_prev <= next_pwr_prev;
    end
  end

  // ----------------------------------------
  // Sync probe selection and phase freeze
  // ----------------------------------------
  logic [1:0] next_probe;
  always_comb begin
    next_probe = 2'b00;
    if (32'(sync_sel_1) < `PIL_NUM_SYNC_SRC) begin
      next_probe[0] = sync_sources[sync_sel_1];
    end
    if (32'(sync_sel_2) < `PIL_NUM_SYNC_SRC) begin
      next_probe[1] = sync_sources[sync_sel_2];
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  // Outputs follow the next state, so power and lamps move on the same edge
  logic halt_lamp_lvl;
  pil_pkg::pil_ctl_t next_ctl;
  pil_pkg::pil_lamps_t next_lamps;
  logic next_reader_ac_power;
  logic next_system_power;
  logic next_interlock_supply;
  logic [NRS-1:0] next_override_lamp;
  logic [NHS-1:0] next_host_override_lamp;
  logic next_interlock_fail_lamp;
  logic next_operational_fail_lamp;
  logic [`PIL_NUM_PHASE-1:0] next_phase_freeze;

  assign halt_lamp_lvl = ready_lost | halt_d;

  always_comb begin
    next_ctl.halt_req = halt_d;
    next_ctl.setup_req = setup_d;
    next_ctl.log_enable = log_en;
    next_ctl.reader_not_ready = halt_lamp_lvl;
    next_lamps.halt_lamp = halt_lamp_lvl;
    next_lamps.setup_lamp = setup_d & param_ready_only;
    next_lamps.log_lamp = log_en;
    next_lamps.power_lamp = (next_st == pil_pkg::PIL_PWR_ON) & dc_supplies_ok;
    next_reader_ac_power = next_st == pil_pkg::PIL_PWR_ON;
    // Only the interlock supplies survive a trip
    next_system_power = next_st != pil_pkg::PIL_PWR_TRIP;
    next_interlock_supply = 1'b1;
    next_override_lamp = rg_eff;
    next_host_override_lamp = hg_eff;
    next_interlock_fail_lamp = next_il_fail;
    next_operational_fail_lamp = next_op_fail;
    next_phase_freeze = freeze_d ? phase_freeze_req : '0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctl <= '0;
      lamps <= '0;
      reader_ac_power <= 1'b0;
      system_power <= 1'b0;
      interlock_supply <= 1'b0;
      override_lamp <= '0;
      host_override_lamp <= '0;
      interlock_fail_lamp <= 1'b0;
      operational_fail_lamp <= 1'b0;
      selectable_sync_probe <= 2'b00;
      phase_freeze <= '0;
    end else begin
      ctl <= next_ctl;
      lamps <= next_lamps;
      reader_ac_power <= next_reader_ac_power;
      system_power <= next_system_power;
      interlock_supply <= next_interlock_supply;
      override_lamp <= next_override_lamp;
      host_override_lamp <= next_host_override_lamp;
      interlock_fail_lamp <= next_interlock_fail_lamp;
      operational_fail_lamp <= next_operational_fail_lamp;
      selectable_sync_probe <= next_probe;
      phase_freeze <= next_phase_freeze;
    end
  end

endmodule

// file: pil_defines.svh
// Constants for the panel and interlock status logic.
// Assumes a 10 MHz system clock; included by its bare name.
`ifndef PIL_DEFINES_SVH
`define PIL_DEFINES_SVH

`define PIL_CLK_HZ 10000000
`define PIL_DEBOUNCE_US 2000
`define PIL_DEBOUNCE_CYC ((`PIL_CLK_HZ / 1000000) * `PIL_DEBOUNCE_US)
`define PIL_NUM_RDR_GUARD 4
`define PIL_NUM_HOST_GUARD 2
`define PIL_NUM_PHASE 8
`define PIL_SYNC_SEL_W 4
`define PIL_NUM_SYNC_SRC 12
`define PIL_NUM_BTN 9
`define PIL_BTN_HALT 0
`define PIL_BTN_SETUP 1
`define PIL_BTN_LOG 2
`define PIL_BTN_PWR 3
`define PIL_BTN_MAINS 4
`define PIL_BTN_HOSTSUP 5
`define PIL_BTN_MAINT 6
`define PIL_BTN_FRESET 7
`define PIL_BTN_FREEZE 8

`endif

// file: pil_pkg.sv
// Types for the panel and interlock status logic.
// Assumes pil_defines.svh is available on the include path.
`include "pil_defines.svh"
package pil_pkg;

  typedef struct packed {
    logic halt_lamp;
    logic setup_lamp;
    logic log_lamp;
    logic power_lamp;
  } pil_lamps_t;

  typedef struct packed {
    logic halt_req;
    logic setup_req;
    logic log_enable;
    logic reader_not_ready;
  } pil_ctl_t;

  typedef enum logic [2:0] {
    PIL_PWR_OFF = 3'b001,
    PIL_PWR_ON = 3'b010,
    PIL_PWR_TRIP = 3'b100
  } pil_pwr_state_t;

endpackage

// file: pil_panel_interlock_asserts.sv
// Checker for the panel and interlock status logic.
// Assumes it is bound to pil_panel_interlock and sees only its ports.
`timescale 1ns/1ps
`include "pil_defines.svh"
module pil_panel_interlock_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic ready_lost,
  input wire logic [`PIL_SYNC_SEL_W-1:0] sync_sel_1,
  input wire logic [`PIL_SYNC_SEL_W-1:0] sync_sel_2,
  input wire logic [`PIL_NUM_SYNC_SRC-1:0] sync_sources,
  input wire logic [`PIL_NUM_PHASE-1:0] phase_freeze_req,
  input wire pil_pkg::pil_ctl_t ctl,
  input wire pil_pkg::pil_lamps_t lamps,
  input wire logic reader_ac_power,
  input wire logic system_power,
  input wire logic interlock_supply,
  input wire logic interlock_fail_lamp,
  input wire logic [1:0] selectable_sync_probe,
  input wire logic [`PIL_NUM_PHASE-1:0] phase_freeze
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_halt_lamp; ready_lost |=> lamps.halt_lamp; endproperty
  a_halt_lamp: assert property (p_halt_lamp) else $error("halt lamp missed lost ready");
  property p_not_ready; ctl.reader_not_ready == lamps.halt_lamp; endproperty
  a_not_ready: assert property (p_not_ready) else $error("not ready differs from halt lamp");
  property p_setup_lamp; lamps.setup_lamp |-> ctl.setup_req; endproperty
  a_setup_lamp: assert property (p_setup_lamp) else $error("setup lamp without button");
  property p_log_lamp; lamps.log_lamp == ctl.log_enable; endproperty
  a_log_lamp: assert property (p_log_lamp) else $error("log lamp differs from option");
  property p_power_lamp; lamps.power_lamp |-> reader_ac_power && system_power; endproperty
  a_power_lamp: assert property (p_power_lamp) else $error("power lamp without power");
  property p_supply; !$past(rst) |-> interlock_supply; endproperty
  a_supply: assert property (p_supply) else $error("interlock supply dropped");
  property p_trip; interlock_fail_lamp |-> !reader_ac_power; endproperty
  a_trip: assert property (p_trip) else $error("power on with failure latched");
  property p_sync;
    !$past(rst) && $past(sync_sel_1) < 4'hc |-> selectable_sync_probe[0] == $past(sync_sources[sync_sel_1]);
  endproperty
  a_sync: assert property (p_sync) else $error("sync probe wrong source");
  property p_sync2;
    !$past(rst) && $past(sync_sel_2) < 4'hc |-> selectable_sync_probe[1] == $past(sync_sources[sync_sel_2]);
  endproperty
  a_sync2: assert property (p_sync2) else $error("second sync probe wrong source");
  property p_freeze; (phase_freeze & ~$past(phase_freeze_req)) == 8'h00; endproperty
  a_freeze: assert property (p_freeze) else $error("phase frozen without request");
endmodule

// file: pil_ctrl_model.sv
// Buffer controller model facing the panel logic.
// Assumes the same clock and reset as the block.
`timescale 1ns/1ps
`include "pil_defines.svh"
module pil_ctrl_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic setup_req,
  output logic param_ready_only,
  output logic [`PIL_NUM_SYNC_SRC-1:0] sync_sources,
  output logic dc_supplies_ok
);
  always_ff @(posedge clk) begin
    if (rst) begin
      param_ready_only <= 1'b0;
      sync_sources <= 12'h5a3;
    end else begin
      param_ready_only <= setup_req;
      sync_sources <= {sync_sources[10:0], ~sync_sources[11]};
    end
  end
  assign dc_supplies_ok = 1'b1;
endmodule

// file: pil_panel_interlock_tb.sv
// Testbench for the panel and interlock status logic.
// Assumes the debounce define is left at its full length.
`timescale 1ns/1ps
`include "pil_defines.svh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin failures++; $display("Error %s exp %0h got %0h", n, e, a); end end
module pil_panel_interlock_tb;
  logic clk = 0, rst = 1, halt = 0, setup = 0, logb = 0, pwr = 0, mains = 0, hsup = 0, maint = 0, frst = 0;
  logic fsel = 0, ofault = 0, rlost = 0, dcok, pro;
  logic [3:0] sovr = 0, sflt = 0, sel1 = 0, sel2 = 0, ovl;
  logic [1:0] hovr = 0, hflt = 0, hovl, probe, exp_probe;
  logic [7:0] freq = 0, frz;
  logic [11:0] src;
  logic acp, sysp, isup, ifail, ofail;
  pil_pkg::pil_ctl_t ctl;
  pil_pkg::pil_lamps_t lamps;
  int failures = 0, cmp_count = 0;
  always #50 clk = ~clk;
  pil_panel_interlock i_pil_panel_interlock (.clk, .rst, .halt_btn(halt), .setup_btn(setup), .log_btn(logb),
    .power_btn(pwr), .mains_permit_sw(mains), .host_supply_sw(hsup), .maint_mode_sw(maint), .fault_reset_btn(frst),
    .phase_freeze_selector(fsel), .scanner_guard_override(sovr), .host_guard_override(hovr), .scanner_fault(sflt),
    .host_fault(hflt), .operational_fault(ofault), .dc_supplies_ok(dcok), .ready_lost(rlost), .param_ready_only(pro),
    .sync_sel_1(sel1), .sync_sel_2(sel2), .sync_sources(src), .phase_freeze_req(freq), .ctl, .lamps,
    .reader_ac_power(acp), .system_power(sysp), .interlock_supply(isup), .override_lamp(ovl),
    .host_override_lamp(hovl), .interlock_fail_lamp(ifail), .operational_fail_lamp(ofail),
    .selectable_sync_probe(probe), .phase_freeze(frz));
  pil_ctrl_model i_pil_ctrl_model (.clk, .rst, .setup_req(ctl.setup_req), .param_ready_only(pro),
    .sync_sources(src), .dc_supplies_ok(dcok));
  task tick(int n); repeat (n) @(posedge clk); #1; endtask
  task settle; tick(20010); endtask
  task end_of_test;
    $display("Comparisons %0d, errors %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task t_same_clock;
    rlost = 1; tick(2);
    `CHK("halt_lamp", 1'b1, lamps.halt_lamp)
    `CHK("not_ready", 1'b1, ctl.reader_not_ready)
    rlost = 0; tick(2);
    `CHK("halt_lamp", 1'b0, lamps.halt_lamp)
    for (int s = 12; s < 16; s++) begin
      sel1 = 4'(s); sel2 = 4'(s); tick(3);
      `CHK("probe", 2'h0, probe)
    end
    sel1 = 4'h3; sel2 = 4'h7;
    for (int s = 0; s < 4; s++) begin
      exp_probe = {src[7], src[3]};
      tick(1);
      `CHK("probe_src", exp_probe, probe)
    end
  endtask
  task t_panel;
    halt = 1; setup = 1; logb = 1; mains = 1; hsup = 1; fsel = 1; freq = 8'ha5; sovr = 4'h9; hovr = 2'h2;
    tick(100);
    `CHK("early_halt", 1'b0, ctl.halt_req)
    settle;
    `CHK("halt_req", 1'b1, ctl.halt_req)
    `CHK("halt_lamp", 1'b1, lamps.halt_lamp)
    `CHK("setup_req", 1'b1, ctl.setup_req)
    `CHK("setup_lamp", 1'b1, lamps.setup_lamp)
    `CHK("log_lamp", 1'b1, lamps.log_lamp)
    `CHK("freeze", 8'ha5, frz)
    `CHK("ovr_lamp", 4'h0, ovl)
    `CHK("host_lamp", 2'h0, hovl)
    `CHK("ac_power", 1'b0, acp)
  endtask
  task t_trip;
    halt = 0; setup = 0; logb = 0; pwr = 1; settle;
    `CHK("setup_lamp", 1'b0, lamps.setup_lamp)
    `CHK("log_lamp", 1'b1, lamps.log_lamp)
    `CHK("log_enable", 1'b1, ctl.log_enable)
    `CHK("ac_power", 1'b1, acp)
    `CHK("power_lamp", 1'b1, lamps.power_lamp)
    sflt = 4'h1; tick(1); sflt = 0; ofault = 1; tick(1); ofault = 0; tick(2);
    `CHK("ac_power", 1'b0, acp)
    `CHK("sys_power", 1'b0, sysp)
    `CHK("il_supply", 1'b1, isup)
    `CHK("op_fail", 1'b1, ofail)
    tick(50);
    `CHK("il_fail", 1'b1, ifail)
  endtask
  task t_maint;
    pwr = 0; maint = 1; frst = 1; settle;
    `CHK("ovr_lamp", 4'h9, ovl)
    `CHK("host_lamp", 2'h2, hovl)
    `CHK("il_fail", 1'b0, ifail)
    frst = 0; pwr = 1; settle;
    sflt = 4'h8; hflt = 2'h2; tick(3);
    `CHK("ac_masked", 1'b1, acp)
    `CHK("il_masked", 1'b0, ifail)
    sflt = 0; hflt = 0;
  endtask
  initial begin
    tick(16); rst = 0; tick(3);
    t_same_clock;
    t_panel;
    t_trip;
    t_maint;
    end_of_test;
  end
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    end_of_test;
  end
endmodule
bind pil_panel_interlock pil_panel_interlock_asserts i_pil_panel_interlock_asserts (.clk, .rst, .ready_lost,
  .sync_sel_1, .sync_sel_2, .sync_sources, .phase_freeze_req, .ctl, .lamps, .reader_ac_power, .system_power,
  .interlock_supply,
  .interlock_fail_lamp, .selectable_sync_probe, .phase_freeze);
